// ===== otb_pkg.sv
// Register map, field layout and reset values for the option and trim access block
package otb_pkg;
  // Printed register indices; byte address on the bus is four times the index
  localparam logic [13:0] OTB_IDX_OPT0  = 14'h0000;  // User option byte zero
  localparam logic [13:0] OTB_IDX_OPT1  = 14'h0001;  // User option byte one
  localparam logic [13:0] OTB_IDX_TADDR = 14'h0FF6;  // Trim address pointer
  localparam logic [13:0] OTB_IDX_TDATA = 14'h0FF7;  // Trim data port
  // Trim space
  localparam int          OTB_TRIM_DEPTH = 32;        // Trim bytes 00H..1FH
  localparam logic [7:0]  OTB_TRIM_LAST  = 8'h1F;     // Highest valid pointer
  localparam logic [7:0]  OTB_TRIM_RSVD  = 8'h04;     // Reserved trim byte
  // Reset and erased values
  localparam logic [7:0]  OTB_PTR_RST    = 8'h00;     // Pointer after reset
  localparam logic [7:0]  OTB_TDATA_RST  = 8'h00;     // Data port after reset
  localparam logic [7:0]  OTB_ERASED     = 8'hFF;     // Unprogrammed flash byte
  // Option byte zero field positions
  localparam int          OTB_F_WDACT    = 7;         // Watchdog time-out action
  localparam int          OTB_F_WDAON    = 6;         // Watchdog always-on
  localparam int          OTB_F_OSC_HI   = 5;         // Oscillator select msb
  localparam int          OTB_F_OSC_LO   = 4;         // Oscillator select lsb
  localparam int          OTB_F_BOAON    = 3;         // Brown-out always-on
  localparam int          OTB_F_RDPROT   = 2;         // Read protect
  localparam int          OTB_F_WRPROT   = 0;         // Write protect
  // Decoded register selection
  typedef enum logic [2:0] {
    OTB_SEL_NONE  = 3'b000,
    OTB_SEL_OPT0  = 3'b001,
    OTB_SEL_OPT1  = 3'b010,
    OTB_SEL_TADDR = 3'b011,
    OTB_SEL_TDATA = 3'b100
  } otb_sel_t;
endpackage

// ===== otb_opt_decode.sv
// Splits option byte zero into its configuration fields
`timescale 1ns/1ps
module otb_opt_decode
  import otb_pkg::*;
(
  input  wire logic       clk_i,                 // System clock
  input  wire logic       rst_i,                 // Synchronous reset, active high
  input  wire logic [7:0] opt_byte_i,            // Stored option byte zero
  output logic            wdog_timeout_action_o, // 1 reset, 0 interrupt
  output logic            wdog_always_on_o,      // 0 forces watchdog on
  output logic [1:0]      osc_source_choice_o,   // Oscillator select
  output logic            brownout_always_on_o,  // Brown-out always-on
  output logic            read_protect_option_o, // 0 when programmed
  output logic            write_protect_option_o // 0 when programmed
);

  // Field extraction, bit 1 is left unused
  always_comb begin
    wdog_timeout_action_o  = opt_byte_i[OTB_F_WDACT];               // [RQ4]
    wdog_always_on_o       = opt_byte_i[OTB_F_WDAON];               // [RQ4]
    osc_source_choice_o    = opt_byte_i[OTB_F_OSC_HI:OTB_F_OSC_LO]; // [RQ4]
    brownout_always_on_o   = opt_byte_i[OTB_F_BOAON];               // [RQ4]
    read_protect_option_o  = opt_byte_i[OTB_F_RDPROT];              // [RQ4]
    write_protect_option_o = opt_byte_i[OTB_F_WRPROT];              // [RQ4]
  end

  // Whole field map checked against the stored byte
  chk_field_map: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    {wdog_timeout_action_o, wdog_always_on_o, osc_source_choice_o, brownout_always_on_o,
     read_protect_option_o, write_protect_option_o} == {opt_byte_i[7:2], opt_byte_i[0]})
    else $error("option field map wrong");

endmodule

// ===== otb_core.sv
// Option byte and trim byte access with Wishbone register slave and option steering
//
// Behaviour
// RQ1: Eight-bit trim pointer, reset zero, 00H..1FH.
// RQ2: Eight-bit trim data port, reset zero.
// RQ3: Program bytes 0000H and 0001H hold options.
// RQ4: Option byte zero field positions fixed.
// RQ5: Action bit 0: time-out raises interrupt.
// RQ6: Action bit 1: time-out forces system reset.
// RQ7: Always-on bit 0: watchdog on, undisableable.
// RQ8: Reset never alters option or trim bytes.
// RQ9: Software leaves reserved trim byte 04H alone.
// RQ10: Read protect blocks debugger code reads.
// RQ11: Data port accesses pointed byte, pointer unchanged.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module otb_core
  import otb_pkg::*;
(
  input  wire logic        clk_i,                 // System clock, 200 MHz
  input  wire logic        rst_i,                 // Synchronous reset, active high
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,              // Cycle
  input  wire logic        wb_stb_i,              // Strobe
  input  wire logic        wb_we_i,               // Write enable
  input  wire logic [15:0] wb_adr_i,              // Byte address
  input  wire logic [3:0]  wb_sel_i,              // Byte lanes
  input  wire logic [31:0] wb_dat_i,              // Write data
  output logic [31:0]      wb_dat_o,              // Read data
  output logic             wb_ack_o,              // Acknowledge
  // Watchdog and system
  input  wire logic        wdog_timeout_i,        // Watchdog time-out pulse
  input  wire logic        wdog_sw_enable_i,      // Software watchdog enable
  output logic             wdog_irq_o,            // Watchdog interrupt request
  output logic             sys_reset_o,           // System reset request
  output logic             wdog_enable_o,         // Watchdog running
  output logic [1:0]       osc_source_choice_o,   // Oscillator select
  output logic             brownout_always_on_o,  // Brown-out always-on
  output logic             write_protect_option_o,// Flash write protect option
  // Code fetch and debugger
  input  wire logic        fetch_valid_i,         // Code fetch in progress
  input  wire logic [15:0] fetch_addr_i,          // Code fetch address
  output logic             fetch_fault_o,         // Fetch hit option bytes
  input  wire logic        dbg_code_read_i,       // Debugger code read request
  output logic             dbg_read_allow_o       // Debugger read permitted
);

  // Non-volatile stores, never touched by reset
  // Erased contents at power-up only, given at declaration so each store keeps a single writer
  logic [7:0] opt0_r = OTB_ERASED;                                    // Option byte zero
  logic [7:0] opt1_r = OTB_ERASED;                                    // Option byte one
  logic [7:0] trim_mem [OTB_TRIM_DEPTH] = '{default: OTB_ERASED};     // Trim bytes
  // Volatile registers
  logic [7:0] trim_ptr_r;                  // Trim address pointer
  logic [7:0] trim_data_r;                 // Trim data port
  logic       ack_r;                       // Bus acknowledge
  logic [31:0] rdata_r;                    // Read data
  logic       wdog_act;                    // Decoded time-out action
  logic       wdog_aon;                    // Decoded always-on
  logic       rd_prot;                     // Decoded read protect
  otb_sel_t   sel;                         // Current register selection
  logic       req;                         // Live bus request
  logic       wr_go;                       // Write takes effect now
  logic       ptr_ok;                      // Pointer inside trim space

  // Index decode, shared by read and write paths
  function automatic otb_sel_t reg_sel(input logic [15:0] adr);
    case (adr[15:2])
      OTB_IDX_OPT0:  reg_sel = OTB_SEL_OPT0;
      OTB_IDX_OPT1:  reg_sel = OTB_SEL_OPT1;
      OTB_IDX_TADDR: reg_sel = OTB_SEL_TADDR;
      OTB_IDX_TDATA: reg_sel = OTB_SEL_TDATA;
      default:       reg_sel = OTB_SEL_NONE;
    endcase
  endfunction

  // Request qualifiers
  always_comb begin
    sel    = reg_sel(wb_adr_i);
    req    = wb_cyc_i && wb_stb_i;
    wr_go  = req && wb_we_i && ack_r && wb_sel_i[0];
    ptr_ok = trim_ptr_r <= OTB_TRIM_LAST;  // [RQ1]
  end

  // Acknowledge one cycle after a request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // Read data captured with the request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      case (sel)
        OTB_SEL_OPT0:  rdata_r <= {24'h00_0000, opt0_r};
        OTB_SEL_OPT1:  rdata_r <= {24'h00_0000, opt1_r};
        OTB_SEL_TADDR: rdata_r <= {24'h00_0000, trim_ptr_r};
        OTB_SEL_TDATA: begin
          // Pointed trim byte, zero outside trim space
          rdata_r <= ptr_ok ? {24'h00_0000, trim_mem[trim_ptr_r[4:0]]} : 32'h0000_0000; // [RQ11]
        end
        default:       rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Trim pointer register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_ptr_r <= OTB_PTR_RST;  // [RQ1]
    end else if (wr_go && sel == OTB_SEL_TADDR) begin
      trim_ptr_r <= wb_dat_i[7:0];  // [RQ1]
    end
  end

  // Trim data port holds the last byte written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_data_r <= OTB_TDATA_RST;  // [RQ2]
    end else if (wr_go && sel == OTB_SEL_TDATA) begin
      trim_data_r <= wb_dat_i[7:0];  // [RQ2]
    end
  end

  // Trim byte store, pointer left as is, no reset term
  always_ff @(posedge clk_i) begin
    if (wr_go && sel == OTB_SEL_TDATA && ptr_ok) begin
      trim_mem[trim_ptr_r[4:0]] <= wb_dat_i[7:0];  // [RQ11] [RQ8]
    end
  end

  // Option bytes, no reset term
  always_ff @(posedge clk_i) begin
    if (wr_go && sel == OTB_SEL_OPT0) begin
      opt0_r <= wb_dat_i[7:0];  // [RQ8]
    end
    if (wr_go && sel == OTB_SEL_OPT1) begin
      opt1_r <= wb_dat_i[7:0];  // [RQ8]
    end
  end

  // Option field decoder
  otb_opt_decode u_dec (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .opt_byte_i             (opt0_r),
    .wdog_timeout_action_o  (wdog_act),
    .wdog_always_on_o       (wdog_aon),
    .osc_source_choice_o    (osc_source_choice_o),
    .brownout_always_on_o   (brownout_always_on_o),
    .read_protect_option_o  (rd_prot),
    .write_protect_option_o (write_protect_option_o)
  );

  // Watchdog time-out routing and enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_irq_o    <= 1'b0;
      sys_reset_o   <= 1'b0;
      wdog_enable_o <= 1'b0;
    end else begin
      wdog_irq_o    <= wdog_timeout_i && !wdog_act;  // [RQ5]
      sys_reset_o   <= wdog_timeout_i && wdog_act;   // [RQ6]
      wdog_enable_o <= !wdog_aon || wdog_sw_enable_i; // [RQ7]
    end
  end

  // Option byte fetch guard and debugger read gate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_fault_o    <= 1'b0;
      dbg_read_allow_o <= 1'b0;
    end else begin
      fetch_fault_o    <= fetch_valid_i && fetch_addr_i[15:1] == 15'h0000;  // [RQ3]
      dbg_read_allow_o <= dbg_code_read_i && rd_prot;                     // [RQ10]
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Bus request sequences
  sequence seq_new_req;
    wb_cyc_i && wb_stb_i && !ack_r;
  endsequence
  sequence seq_data_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && ack_r && sel == OTB_SEL_TDATA;
  endsequence

  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_new_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
  chk_ptr_reset: assert property (@(posedge clk_i) rst_i |=> trim_ptr_r == 8'h00) // [RQ1]
    else $error("pointer not zero after reset");
  chk_data_reset: assert property (@(posedge clk_i) rst_i |=> trim_data_r == 8'h00) // [RQ2]
    else $error("data port not zero after reset");
  chk_ptr_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
    seq_data_wr |=> $stable(trim_ptr_r) && trim_data_r == $past(wb_dat_i[7:0]))
    else $error("data write moved pointer or lost data");
  chk_read_trim: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
    seq_new_req ##0 (!wb_we_i && sel == OTB_SEL_TDATA && ptr_ok)
      |=> wb_ack_o && wb_dat_o[7:0] == trim_mem[$past(trim_ptr_r[4:0])])
    else $error("data port read wrong byte");
  chk_opt_keep: assert property (@(posedge clk_i) rst_i |=> $stable(opt0_r) && $stable(opt1_r)) // [RQ8]
    else $error("reset altered option bytes");
  chk_wdog_irq: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    wdog_timeout_i && !opt0_r[7] |=> wdog_irq_o && !sys_reset_o)
    else $error("time-out did not raise interrupt");
  chk_wdog_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    wdog_timeout_i && opt0_r[7] |=> sys_reset_o && !wdog_irq_o)
    else $error("time-out did not force reset");
  chk_wdog_forced: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    !opt0_r[6] && $stable(opt0_r) |=> wdog_enable_o)
    else $error("watchdog not forced on");
  chk_dbg_block: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
    !opt0_r[2] |=> !dbg_read_allow_o)
    else $error("debugger read not blocked");
  chk_fetch_fault: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
    fetch_valid_i && fetch_addr_i < 16'h0002 |=> fetch_fault_o)
    else $error("option byte fetch not flagged");

endmodule

// ===== tb_top.sv
// Self-checking bench for the option and trim access block
`timescale 1ns/1ps
module tb_top;
  import otb_pkg::*;
  localparam logic [15:0] A_OPT0 = 16'h0000;  // Option byte zero
  localparam logic [15:0] A_OPT1 = 16'h0004;  // Option byte one
  localparam logic [15:0] A_PTR  = 16'h3FD8;  // Trim pointer
  localparam logic [15:0] A_DAT  = 16'h3FDC;  // Trim data port
  localparam logic [15:0] A_GAP  = 16'h0100;  // Unmapped
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;  // Clock, reset, bus control
  logic [15:0] wb_adr_i, fetch_addr_i;       // Bus and fetch addresses
  logic [3:0]  wb_sel_i;                     // Byte lanes
  logic [31:0] wb_dat_i, wb_dat_o, rd;       // Bus data
  logic        wdog_timeout_i, wdog_sw_enable_i, wdog_irq_o, sys_reset_o, wdog_enable_o;  // Watchdog
  logic [1:0]  osc_source_choice_o;          // Oscillator field
  logic        brownout_always_on_o, write_protect_option_o;  // Option fields
  logic        fetch_valid_i, fetch_fault_o, dbg_code_read_i, dbg_read_allow_o;  // Fetch and debug
  int          fails, check_count;           // Mismatches and comparisons
  otb_core otb_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wdog_timeout_i(wdog_timeout_i), .wdog_sw_enable_i(wdog_sw_enable_i),
    .wdog_irq_o(wdog_irq_o), .sys_reset_o(sys_reset_o), .wdog_enable_o(wdog_enable_o),
    .osc_source_choice_o(osc_source_choice_o), .brownout_always_on_o(brownout_always_on_o),
    .write_protect_option_o(write_protect_option_o), .fetch_valid_i(fetch_valid_i),
    .fetch_addr_i(fetch_addr_i), .fetch_fault_o(fetch_fault_o), .dbg_code_read_i(dbg_code_read_i),
    .dbg_read_allow_o(dbg_read_allow_o));
  // Free-running 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [7:0] dat, input logic [3:0] sel,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= adr; wb_sel_i <= sel; wb_dat_i <= {24'h00_0000, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      check("ack timeout", 32'h0000_0000, 32'h0000_0001);
      stop_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
  endtask
  // Byte write in lane zero
  task automatic wb_write(input logic [15:0] adr, input logic [7:0] dat);
    wb_xfer(1'b1, adr, dat, 4'h1, rd);
  endtask
  // Read and compare
  task automatic rd_chk(input string name, input logic [15:0] adr, input logic [7:0] exp);
    wb_xfer(1'b0, adr, 8'h00, 4'hF, rd);
    check(name, {24'h00_0000, exp}, rd);
  endtask
  // Advance to the next rising edge, where inputs are driven
  task automatic tick;
    @(posedge clk_i);
  endtask
  // Wait to mid-cycle, where registered outputs have settled
  task automatic settle;
    @(negedge clk_i);
  endtask
  // Verdict
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog on a hang
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  // Main sequence
  initial begin
    fails = 0; check_count = 0; rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 16'h0000; wb_sel_i = 4'h0; wb_dat_i = 32'h0000_0000; wdog_timeout_i = 1'b0;
    wdog_sw_enable_i = 1'b0; fetch_valid_i = 1'b0; fetch_addr_i = 16'h0000; dbg_code_read_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ptr reset", A_PTR, OTB_PTR_RST);
    rd_chk("erased trim", A_DAT, OTB_ERASED);
    wb_write(A_PTR, OTB_TRIM_LAST);  // reserved 04H left untouched
    wb_write(A_DAT, 8'h5A);
    rd_chk("ptr kept", A_PTR, OTB_TRIM_LAST);
    rd_chk("trim byte", A_DAT, 8'h5A);
    wb_write(A_PTR, 8'h20);
    rd_chk("ptr beyond", A_DAT, 8'h00);
    rd_chk("unmapped", A_GAP, 8'h00);
    wb_xfer(1'b1, A_OPT1, 8'h12, 4'h0, rd);
    rd_chk("lane off", A_OPT1, OTB_ERASED);
    wb_write(A_OPT0, 8'h3A);
    rd_chk("opt0", A_OPT0, 8'h3A);
    wb_write(A_OPT1, 8'h12);
    rd_chk("opt1", A_OPT1, 8'h12);
    settle();
    check("osc", 32'h3, {30'h0, osc_source_choice_o});
    check("brownout", 32'h1, {31'h0, brownout_always_on_o});
    check("wprot", 32'h0, {31'h0, write_protect_option_o});
    check("forced on", 32'h1, {31'h0, wdog_enable_o});
    check("dbg blocked", 32'h0, {31'h0, dbg_read_allow_o});
    tick();
    wdog_timeout_i <= 1'b1;
    tick();
    wdog_timeout_i <= 1'b0;
    settle();
    check("irq", 32'h1, {31'h0, wdog_irq_o});
    check("no reset", 32'h0, {31'h0, sys_reset_o});
    wb_write(A_OPT0, 8'hC5);
    tick();
    settle();
    check("osc0", 32'h0, {30'h0, osc_source_choice_o});
    check("brownout0", 32'h0, {31'h0, brownout_always_on_o});
    check("wprot1", 32'h1, {31'h0, write_protect_option_o});
    check("sw off", 32'h0, {31'h0, wdog_enable_o});
    check("dbg allowed", 32'h1, {31'h0, dbg_read_allow_o});
    tick();
    wdog_timeout_i   <= 1'b1;
    wdog_sw_enable_i <= 1'b1;
    dbg_code_read_i  <= 1'b0;
    fetch_valid_i    <= 1'b1;
    fetch_addr_i     <= 16'h0001;
    tick();
    wdog_timeout_i <= 1'b0;
    fetch_addr_i   <= 16'h0002;
    settle();
    check("sys reset", 32'h1, {31'h0, sys_reset_o});
    check("no irq", 32'h0, {31'h0, wdog_irq_o});
    check("fetch fault", 32'h1, {31'h0, fetch_fault_o});
    check("sw on", 32'h1, {31'h0, wdog_enable_o});
    check("no request", 32'h0, {31'h0, dbg_read_allow_o});
    tick();
    settle();
    check("code fetch", 32'h0, {31'h0, fetch_fault_o});
    tick();
    fetch_valid_i <= 1'b0;
    rst_i         <= 1'b1;
    repeat (2) tick();
    rst_i <= 1'b0;
    rd_chk("ptr rereset", A_PTR, OTB_PTR_RST);
    rd_chk("opt0 kept", A_OPT0, 8'hC5);
    wb_write(A_PTR, OTB_TRIM_LAST);
    rd_chk("trim kept", A_DAT, 8'h5A);
    stop_test();
  end
endmodule
